/* File: hw/arb_pkg.sv */
// Constants and types for the priority daisy-chain bus arbitrator
package arb_pkg;
	localparam int unsigned LEVEL_COUNT = 5;
	localparam int unsigned ADDR_WIDTH = 18;
	localparam int unsigned DATA_WIDTH = 16;
	localparam int unsigned BYTE_WIDTH = 8;
	// Index of the nonprocessor level inside the five-bit vectors
	localparam int unsigned TOP_LEVEL_INDEX = 4;
	// Processor priority field width and reset value
	localparam int unsigned CPU_LEVEL_WIDTH = 3;
	localparam logic [2:0] CPU_LEVEL_RESET = 3'h7;
	// Time a grant may ripple the chain before it is withdrawn
	localparam int unsigned CHAIN_TIMEOUT_NS = 200;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned CHAIN_TIMEOUT_CYCLES = CHAIN_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int unsigned TIMER_WIDTH = 8;
	// Slave window reset values
	localparam logic [17:0] SLAVE_BASE_RESET = 18'h00000;
	localparam logic [17:0] SLAVE_MASK_RESET = 18'h3f000;

	typedef enum logic [2:0] {
		ARB_IDLE  = 3'h1,
		ARB_GRANT = 3'h2,
		ARB_WAIT  = 3'h4
	} arb_state_type;
endpackage

/* File: hw/priority_daisy_chain_arbiter.sv */
// Priority daisy-chain bus arbitrator with address-based slave select
`timescale 1ns/1ps
`default_nettype none

module priority_daisy_chain_arbiter
	import arb_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = CHAIN_TIMEOUT_CYCLES
) (
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire logic [arb_pkg::LEVEL_COUNT-1:0]     request_in,
	input  wire logic [arb_pkg::CPU_LEVEL_WIDTH-1:0] cpu_level,
	input  wire logic                                cpu_int_ready,
	input  wire logic                                select_ack_in,
	input  wire logic                                bus_busy_in,
	input  wire logic [arb_pkg::LEVEL_COUNT-1:0]     grant_return_in,
	input  wire logic [arb_pkg::ADDR_WIDTH-1:0]      addr_in,
	input  wire logic                                addr_valid_in,
	input  wire logic [arb_pkg::ADDR_WIDTH-1:0]      slave_base,
	input  wire logic [arb_pkg::ADDR_WIDTH-1:0]      slave_mask,
	output logic      [arb_pkg::LEVEL_COUNT-1:0]     grant_out,
	output logic                                     cpu_bus_free,
	output logic                                     slave_selected,
	output logic                                     slave_byte_lane
);
	import arb_pkg::*;

	// ********************************
	// Input synchronisers
	// ********************************
	logic [LEVEL_COUNT-1:0] req_meta_ff;
	logic [LEVEL_COUNT-1:0] req_sync_ff;
	logic [CPU_LEVEL_WIDTH-1:0] lvl_meta_ff;
	logic [CPU_LEVEL_WIDTH-1:0] lvl_sync_ff;
	logic [2:0] ctl_meta_ff;
	logic [2:0] ctl_sync_ff;
	logic [LEVEL_COUNT-1:0] ret_meta_ff;
	logic [LEVEL_COUNT-1:0] ret_sync_ff;
	logic [ADDR_WIDTH:0] adr_meta_ff;
	logic [ADDR_WIDTH:0] adr_sync_ff;
	logic [ADDR_WIDTH-1:0] base_meta_ff;
	logic [ADDR_WIDTH-1:0] base_sync_ff;
	logic [ADDR_WIDTH-1:0] mask_meta_ff;
	logic [ADDR_WIDTH-1:0] mask_sync_ff;
	logic                  valid_dly_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_meta_ff <= '0;
			req_sync_ff <= '0;
			lvl_meta_ff <= CPU_LEVEL_RESET;
			lvl_sync_ff <= CPU_LEVEL_RESET;
			ctl_meta_ff <= '0;
			ctl_sync_ff <= '0;
			ret_meta_ff <= '0;
			ret_sync_ff <= '0;
			adr_meta_ff <= '0;
			adr_sync_ff <= '0;
			base_meta_ff <= SLAVE_BASE_RESET;
			base_sync_ff <= SLAVE_BASE_RESET;
			mask_meta_ff <= SLAVE_MASK_RESET;
			mask_sync_ff <= SLAVE_MASK_RESET;
			valid_dly_ff <= 1'b0;
		end else begin
			req_meta_ff <= request_in;
			req_sync_ff <= req_meta_ff;
			lvl_meta_ff <= cpu_level;
			lvl_sync_ff <= lvl_meta_ff;
			ctl_meta_ff <= {cpu_int_ready, select_ack_in, bus_busy_in};
			ctl_sync_ff <= ctl_meta_ff;
			ret_meta_ff <= grant_return_in;
			ret_sync_ff <= ret_meta_ff;
			adr_meta_ff <= {addr_valid_in, addr_in};
			adr_sync_ff <= adr_meta_ff;
			base_meta_ff <= slave_base;
			base_sync_ff <= base_meta_ff;
			mask_meta_ff <= slave_mask;
			mask_sync_ff <= mask_meta_ff;
			// Valid one cycle older than the synced address word
			valid_dly_ff <= adr_sync_ff[ADDR_WIDTH];
		end
	end

	wire int_ready = ctl_sync_ff[2];
	wire ack       = ctl_sync_ff[1];
	wire busy      = ctl_sync_ff[0];

	// ********************************
	// Priority compare
	// ********************************
	// Level n (0..3) is interrupt level n+4; top bit is nonprocessor level
	wire [LEVEL_COUNT-1:0] lvl_ok;
	genvar gi;
	generate
		for (gi = 0; gi < LEVEL_COUNT - 1; gi++) begin : g_lvl
			assign lvl_ok[gi] = int_ready && (lvl_sync_ff < CPU_LEVEL_WIDTH'(gi + 4));
		end
	endgenerate
	assign lvl_ok[TOP_LEVEL_INDEX] = 1'b1;

	wire [LEVEL_COUNT-1:0] eligible = req_sync_ff & lvl_ok;

	// Highest eligible level wins; one-hot result
	logic [LEVEL_COUNT-1:0] pick;
	always_comb begin
		pick = '0;
		for (int i = 0; i < LEVEL_COUNT; i++) begin
			if (eligible[i]) begin
				pick = '0;
				pick[i] = 1'b1;
			end
		end
	end
	wire any_pick = |eligible;

	// ********************************
	// Grant sequencer
	// ********************************
	arb_state_type state_ff;
	arb_state_type nxt_state;
	logic [LEVEL_COUNT-1:0] grant_ff;
	logic [LEVEL_COUNT-1:0] nxt_grant;
	logic [TIMER_WIDTH-1:0] timer_ff;
	logic [TIMER_WIDTH-1:0] nxt_timer;
	logic cpu_free_ff;

	wire timed_out   = (timer_ff >= TIMER_WIDTH'(TIMEOUT_CYCLES));
	wire chain_end   = |(grant_ff & ret_sync_ff);
	// Returns of a withdrawn grant linger two cycles in the synchroniser
	wire ret_pending = |ret_sync_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_grant = grant_ff;
		nxt_timer = '0;
		case (state_ff)
			ARB_IDLE: begin
				if (any_pick && !ret_pending) begin
					nxt_state = ARB_GRANT;
					nxt_grant = pick;
				end
			end
			ARB_GRANT: begin
				nxt_timer = timer_ff + 1'b1;
				if (ack) begin
					nxt_state = ARB_WAIT;
					nxt_grant = '0;
				end else if (chain_end || timed_out) begin
					nxt_state = ARB_IDLE;
					nxt_grant = '0;
				end
			end
			ARB_WAIT: begin
				// Next master takes over only after the current one leaves
				if (!ack) begin
					nxt_state = ARB_IDLE;
				end
			end
			default: begin
				nxt_state = ARB_IDLE;
				nxt_grant = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff    <= ARB_IDLE;
			grant_ff    <= '0;
			timer_ff    <= '0;
			cpu_free_ff <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			grant_ff    <= nxt_grant;
			timer_ff    <= nxt_timer;
			cpu_free_ff <= !busy && !eligible[TOP_LEVEL_INDEX] && (state_ff == ARB_IDLE)
				&& !any_pick;
		end
	end

	assign grant_out    = grant_ff;
	assign cpu_bus_free = cpu_free_ff;

	// ********************************
	// Slave address decode
	// ********************************
	logic sel_ff;
	logic lane_ff;
	wire [ADDR_WIDTH-1:0] adr = adr_sync_ff[ADDR_WIDTH-1:0];
	// Decode only once the valid bit has stood a full cycle; address bits are compared as they stand that cycle
	wire hit = adr_sync_ff[ADDR_WIDTH] && valid_dly_ff
		&& ((adr & mask_sync_ff) == (base_sync_ff & mask_sync_ff));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel_ff  <= 1'b0;
			lane_ff <= 1'b0;
		end else begin
			sel_ff  <= hit;
			lane_ff <= adr[0];
		end
	end

	assign slave_selected  = sel_ff;
	assign slave_byte_lane = lane_ff;
endmodule

`default_nettype wire

/* File: bench/arb_sva.sv */
// Port assertions for the priority arbitrator
`timescale 1ns/1ps
`default_nettype none
module arb_sva #(
	parameter int unsigned TIMEOUT_CYCLES = 5
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [4:0] request_in,
	input wire logic       cpu_int_ready,
	input wire logic       select_ack_in,
	input wire logic [4:0] grant_return_in,
	input wire logic [4:0] grant_out,
	input wire logic       cpu_bus_free
);
	logic [7:0] held_ff;
	always_ff @(posedge clk)
		held_ff <= (!rst_n || grant_out == 5'h00) ? 8'h00 : held_ff + 8'h01;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_grant_onehot: assert property ($onehot0(grant_out)) else $error("two grants");
	a_grant_held: assert property ($rose(|grant_out) |=> $stable(grant_out)[*2])
		else $error("grant dropped early");
	a_grant_timeout: assert property (held_ff <= TIMEOUT_CYCLES + 2)
		else $error("grant overstayed");
	a_return_cancel: assert property ((grant_out & grant_return_in) != 5'h00 |->
		##[1:4] grant_out == 5'h00) else $error("unclaimed grant kept");
	a_ack_release: assert property (|grant_out && select_ack_in |->
		##[1:4] grant_out == 5'h00) else $error("accepted grant kept");
	a_free_idle: assert property (cpu_bus_free |-> grant_out == 5'h00)
		else $error("bus free while granting");
	a_low_ready: assert property ($rose(|grant_out[3:0]) |-> $past(cpu_int_ready, 3))
		else $error("grant while not ready");
	a_top_first: assert property ($rose(|grant_out[3:0]) |-> !$past(request_in[4], 3))
		else $error("lower level beat top");
endmodule
bind priority_daisy_chain_arbiter arb_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) sva (
	.clk(clk),
	.rst_n(rst_n),
	.request_in(request_in),
	.cpu_int_ready(cpu_int_ready),
	.select_ack_in(select_ack_in),
	.grant_return_in(grant_return_in),
	.grant_out(grant_out),
	.cpu_bus_free(cpu_bus_free)
);
`default_nettype wire

/* File: bench/bus_devices_model.sv */
// Devices on the grant chains: request, accept or pass grants
`timescale 1ns/1ps
`default_nettype none
module bus_devices_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [4:0] want,
	input  wire logic [4:0] lost,
	input  wire logic [4:0] grant_out,
	output logic      [4:0] request_in,
	output logic            select_ack_in,
	output logic      [4:0] grant_return_in
);
	logic [4:0] acked_ff;
	assign request_in = want | lost;
	assign select_ack_in = |acked_ff;
	assign grant_return_in = grant_out & ~want;
	always_ff @(posedge clk)
		acked_ff <= rst_n ? (want & (acked_ff | grant_out)) : 5'h00;
endmodule
`default_nettype wire

/* File: bench/priority_daisy_chain_arbiter_tb.sv */
// Self-checking bench for the arbitrator
`timescale 1ns/1ps
`default_nettype none
module priority_daisy_chain_arbiter_tb;
	logic        clk = 1'b0, rst_n = 1'b0, cpu_int_ready = 1'b1, bus_busy_in = 1'b0;
	logic        addr_valid_in = 1'b0, select_ack_in, cpu_bus_free, slave_selected;
	logic        slave_byte_lane;
	logic [4:0]  want = 5'h00, lost = 5'h00, request_in, grant_return_in, grant_out, g;
	logic [2:0]  cpu_level = 3'h0;
	logic [17:0] addr_in = 18'h00000, slave_base = 18'h01000, slave_mask = 18'h3f000;
	int          n_fail = 0, checks_done = 0;
	priority_daisy_chain_arbiter #(.TIMEOUT_CYCLES(5)) DUT (
		.clk(clk),
		.rst_n(rst_n),
		.request_in(request_in),
		.cpu_level(cpu_level),
		.cpu_int_ready(cpu_int_ready),
		.select_ack_in(select_ack_in),
		.bus_busy_in(bus_busy_in),
		.grant_return_in(grant_return_in),
		.addr_in(addr_in),
		.addr_valid_in(addr_valid_in),
		.slave_base(slave_base),
		.slave_mask(slave_mask),
		.grant_out(grant_out),
		.cpu_bus_free(cpu_bus_free),
		.slave_selected(slave_selected),
		.slave_byte_lane(slave_byte_lane)
	);
	bus_devices_model partner (
		.clk(clk),
		.rst_n(rst_n),
		.want(want),
		.lost(lost),
		.grant_out(grant_out),
		.request_in(request_in),
		.select_ack_in(select_ack_in),
		.grant_return_in(grant_return_in)
	);
	initial forever #2 clk = ~clk;
	task automatic chk(input string what, input logic [4:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Drive requests, then wait up to 20 cycles for a grant
	task automatic ask(input logic [4:0] w, l);
		@(posedge clk);
		want <= w;
		lost <= l;
		g = 5'h00;
		for (int i = 0; i < 20 && g == 5'h00; i++) begin
			@(posedge clk);
			#1 g = grant_out;
		end
	endtask
	// Wait up to 4 cycles for the grant to be withdrawn
	task automatic drop_wait;
		for (int i = 0; i < 4 && g != 5'h00; i++) begin
			@(posedge clk);
			#1 g = grant_out;
		end
	endtask
	task automatic settle;
		repeat (6) @(posedge clk);
		want <= 5'h00;
		lost <= 5'h00;
		repeat (10) @(posedge clk);
	endtask
	task automatic addr_case(input logic [17:0] a, input logic hit);
		@(posedge clk);
		addr_in <= a;
		addr_valid_in <= 1'b1;
		repeat (5) @(posedge clk);
		#1 chk("slave hit", {4'h0, hit}, {4'h0, slave_selected});
		chk("byte lane", {4'h0, a[0]}, {4'h0, slave_byte_lane});
		@(posedge clk);
		addr_valid_in <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		bus_busy_in <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			ask(5'h01 << i, 5'h00);
			chk("level grant", 5'h01 << i, g);
			settle;
		end
		chk("busy bus", 5'h00, {4'h0, cpu_bus_free});
		bus_busy_in <= 1'b0;
		ask(5'h11, 5'h00);
		chk("top wins", 5'h10, g);
		settle;
		cpu_int_ready <= 1'b0;
		ask(5'h02, 5'h00);
		chk("not ready", 5'h00, g);
		cpu_int_ready <= 1'b1;
		cpu_level <= 3'h5;
		ask(5'h02, 5'h00);
		chk("level not above", 5'h00, g);
		chk("cpu keeps bus", 5'h01, {4'h0, cpu_bus_free});
		cpu_level <= 3'h4;
		ask(5'h02, 5'h00);
		chk("level above", 5'h02, g);
		settle;
		ask(5'h00, 5'h04);
		chk("unclaimed grant", 5'h04, g);
		drop_wait;
		chk("grant withdrawn", 5'h00, g);
		settle;
		addr_case(18'h01235, 1'b1);
		addr_case(18'h02234, 1'b0);
		summarize;
	end
endmodule
`default_nettype wire
